// File: core/lsub_bridge.sv
// load/store bus to unified bus bridge with data protection unit
// ----------------------------------------------------------------------------
// Notes on behaviour
// - unified-bus inbound wins simultaneous starts
// - forward non-local loads/stores; pass inbound through
// - unified side never issues back-to-back accesses
// - start unified cycle only at depth <=1
// - inbound accesses taken one at a time
// - load/store side carries one transaction
// - module select for one programmable block
// - no dual mapping of local spaces
// - show cycles: none, all, writes only
// - sram protect blocks unified-side sram access
// - four regions with base and size
// - sizes 4 Kbytes to 16 Mbytes
// - base aligned to size; overlap allowed
// - region: privilege, guarded, enable, read-only
// - global default privilege and guarded
// - interrupt on violation, guarded load, ro write
// - data relocate bit enables checking
// - local sram accesses are not checked
// - lowest matching region wins, global last
// - speculative guarded access is retried
// - denied access raises storage exception
// - soft reset idles; hard reset clears registers
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
module lsub_bridge
  import lsub_pkg::*;
#(
  parameter int LBLK_LOG2 = 15,
  parameter int NREG      = 4
) (
  // clock and resets
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              soft_rst,
  // apb register port
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // processor load/store requests
  input  wire logic              ls_req,
  input  wire logic [31:0]       ls_addr,
  input  wire logic              ls_we,
  input  wire logic [31:0]       ls_wdata,
  input  wire logic              ls_user,
  input  wire logic              ls_spec,
  input  wire logic              ls_cancel,
  input  wire logic              data_relocate_bit,
  output logic                   ls_ack,
  output logic                   ls_retry,
  output logic                   ls_dsi,
  output logic [31:0]            ls_rdata,
  output logic                   ls_mod_sel,
  output logic                   prot_irq,
  // load/store bus master (inbound traffic)
  output logic                   lm_req,
  output logic [31:0]            lm_addr,
  output logic                   lm_we,
  output logic [31:0]            lm_wdata,
  input  wire logic              lm_ack,
  input  wire logic [31:0]       lm_rdata,
  // unified bus slave (inbound)
  input  wire logic              us_req,
  input  wire logic [31:0]       us_addr,
  input  wire logic              us_we,
  input  wire logic [31:0]       us_wdata,
  output logic                   us_ack,
  output logic                   us_err,
  output logic [31:0]            us_rdata,
  // unified bus master (outbound and show)
  output logic                   um_req,
  output logic [31:0]            um_addr,
  output logic                   um_we,
  output logic [31:0]            um_wdata,
  output logic                   um_show,
  input  wire logic              um_ack,
  input  wire logic [31:0]       um_rdata,
  input  wire logic [1:0]        um_pipe_depth
);
  import lsub_pkg::*;

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  logic [NREG-1:0][31:0] rba;
  logic [NREG-1:0][31:0] ra;
  logic [31:0]           gra;
  logic [31:0]           ctrl;
  logic [31:0]           lblk;
  lsub_state_t           state;
  logic [2:0]            last_evt;

  logic        wr_en;
  logic        rd_en;
  logic        hit_map;
  logic [31:0] rd_val;
  lsub_show_t  show_mode;
  logic        sram_prot;
  logic [31:0] blk_mask;
  logic        ls_local;
  logic        us_local;
  logic        d_super;
  logic        d_guard;
  logic        d_ro;
  logic        spec_hold;
  logic        viol;
  logic        want_show;
  logic        pipe_ok;

  assign wr_en     = psel && penable && pwrite && !pready;
  assign rd_en     = psel && penable && !pwrite && !pready;
  assign show_mode = lsub_show_t'(ctrl[LSUB_CTRL_SHOW +: 2]);
  assign sram_prot = ctrl[LSUB_CTRL_SPROT];
  assign pipe_ok   = um_pipe_depth <= LSUB_PIPE_MAX;

  // --------------------------------------------------------------------------
  // apb slave
  // --------------------------------------------------------------------------
  always_comb begin
    hit_map = 1'b1;
    rd_val  = 32'h0000_0000;
    if (paddr[1:0] != 2'b00) begin
      hit_map = 1'b0;
    end else if (paddr < LSUB_OFF_RA0) begin
      rd_val = rba[paddr[3:2]];
    end else if (paddr < LSUB_OFF_GRA) begin
      rd_val = ra[paddr[3:2]];
    end else begin
      case (paddr)
        LSUB_OFF_GRA:  rd_val = gra;
        LSUB_OFF_CTRL: rd_val = ctrl;
        LSUB_OFF_LBLK: rd_val = lblk;
        LSUB_OFF_STAT: rd_val = {26'h0, last_evt, state};
        default:       hit_map = 1'b0;
      endcase
    end
  end

  // answer in the second access cycle; pready is a flop so outputs stay clean
  always_ff @(posedge clk) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= rd_en && hit_map ? rd_val : 32'h0000_0000;
      pslverr <= psel && penable && !pready && !hit_map;
    end
  end

  // configuration writes; only hard reset clears them
  always_ff @(posedge clk) begin
    if (rst) begin
      rba  <= {NREG{LSUB_RST_RBA}};
      ra   <= {NREG{LSUB_RST_RA}};
      gra  <= LSUB_RST_GRA;
      ctrl <= LSUB_RST_CTRL;
      lblk <= LSUB_RST_LBLK;
    end else if (wr_en && hit_map) begin
      if (paddr < LSUB_OFF_RA0) begin
        // low bits below the smallest region are not stored
        rba[paddr[3:2]] <= {pwdata[31:LSUB_BASE_LSB], 12'h000};
      end else if (paddr < LSUB_OFF_GRA) begin
        ra[paddr[3:2]] <= {25'h0, pwdata[6:0]};
      end else if (paddr == LSUB_OFF_GRA) begin
        gra <= {20'h0, pwdata[11:8], 2'h0, pwdata[5:4], 4'h0};
      end else if (paddr == LSUB_OFF_CTRL) begin
        ctrl <= {29'h0, pwdata[2:0]};
      end else if (paddr == LSUB_OFF_LBLK) begin
        lblk <= pwdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // decode and protection
  // --------------------------------------------------------------------------
  // the local block; raw address, no dual-map alias into it
  assign blk_mask = 32'hffff_ffff << LBLK_LOG2;
  assign ls_local = ((ls_addr ^ lblk) & blk_mask) == 32'h0000_0000;
  assign us_local = ((us_addr ^ lblk) & blk_mask) == 32'h0000_0000;

  lsub_dpu #(
    .NREG (NREG)
  ) u_dpu (
    .rba        (rba),
    .ra         (ra),
    .gra        (gra),
    .addr       (ls_addr),
    .super_only (d_super),
    .guarded    (d_guard),
    .rdonly     (d_ro)
  );

  // checking off: everything counts as guarded, no exceptions
  // speculative guarded access waits, even when also a violation
  assign spec_hold = ls_spec && (!data_relocate_bit || d_guard);
  // privilege and read-only checks; drive the exception
  assign viol      = data_relocate_bit && ((ls_user && d_super) || (ls_we && d_ro));
  assign want_show = (show_mode == LSUB_SHOW_ALL) || (show_mode == LSUB_SHOW_WRITES && ls_we);

  // --------------------------------------------------------------------------
  // transaction sequencer
  // --------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    ls_ack     <= 1'b0;
    ls_retry   <= 1'b0;
    ls_dsi     <= 1'b0;
    ls_mod_sel <= 1'b0;
    prot_irq   <= 1'b0;
    us_ack     <= 1'b0;
    us_err     <= 1'b0;
    // either reset idles and drops pending work
    if (rst || soft_rst) begin
      state    <= LSUB_ST_IDLE;
      lm_req   <= 1'b0;
      um_req   <= 1'b0;
      um_show  <= 1'b0;
      lm_addr  <= 32'h0000_0000;
      lm_we    <= 1'b0;
      lm_wdata <= 32'h0000_0000;
      um_addr  <= 32'h0000_0000;
      um_we    <= 1'b0;
      um_wdata <= 32'h0000_0000;
      ls_rdata <= 32'h0000_0000;
      us_rdata <= 32'h0000_0000;
      last_evt <= 3'h0;
    end else begin
      case (state)
        LSUB_ST_IDLE: begin
          if (us_req) begin
            if (us_local && sram_prot) begin
              // sram closed to the unified side
              us_err <= 1'b1;
              state  <= LSUB_ST_GAP;
            end else begin
              lm_req   <= 1'b1;
              lm_addr  <= us_addr;
              lm_we    <= us_we;
              lm_wdata <= us_wdata;
              state    <= LSUB_ST_IN;
            end
          end else if (ls_req && ls_local) begin
            // local sram skips the protection unit
            ls_mod_sel <= 1'b1;
            um_addr    <= ls_addr;
            um_we      <= ls_we;
            um_wdata   <= ls_wdata;
            state      <= want_show ? LSUB_ST_SHOW : LSUB_ST_GAP;
            ls_ack     <= !want_show;
          end else if (ls_req) begin
            if (spec_hold) begin
              ls_retry <= 1'b1;
              prot_irq <= data_relocate_bit && !ls_we;
              last_evt <= 3'h1;
            end else if (viol) begin
              ls_dsi   <= 1'b1;
              prot_irq <= 1'b1;
              last_evt <= {ls_we && d_ro, 2'h2};
            end else begin
              um_addr  <= ls_addr;
              um_we    <= ls_we;
              um_wdata <= ls_wdata;
              state    <= LSUB_ST_WAIT;
            end
            if (spec_hold || viol) begin
              state <= LSUB_ST_GAP;
            end
          end
        end
        LSUB_ST_IN: begin
          if (lm_ack) begin
            lm_req   <= 1'b0;
            us_ack   <= 1'b1;
            us_rdata <= lm_rdata;
            state    <= LSUB_ST_GAP;
          end
        end
        LSUB_ST_WAIT, LSUB_ST_SHOW: begin
          if (ls_cancel) begin
            state <= LSUB_ST_GAP;
          end else if (pipe_ok) begin
            // launch only at shallow pipe depth
            um_req  <= 1'b1;
            um_show <= state == LSUB_ST_SHOW;
            state   <= LSUB_ST_OUT;
          end
        end
        LSUB_ST_OUT: begin
          if (um_ack) begin
            um_req   <= 1'b0;
            um_show  <= 1'b0;
            ls_ack   <= 1'b1;
            ls_rdata <= um_show ? 32'h0000_0000 : um_rdata;
            state    <= LSUB_ST_GAP;
          end
        end
        // one idle cycle between any two accesses
        LSUB_ST_GAP: state <= LSUB_ST_IDLE;
        default:     state <= LSUB_ST_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || soft_rst);

  chk_inbound_first: assert property (
    state == LSUB_ST_IDLE && us_req && ls_req && !(us_local && sram_prot) |=> lm_req && !ls_ack && !ls_retry)
    else $error("inbound request lost arbitration");

  chk_no_back2back: assert property (
    $fell(um_req) |=> !um_req ##1 !um_req)
    else $error("unified accesses issued back to back");

  chk_pipe_gate: assert property (
    $rose(um_req) |-> $past(um_pipe_depth) <= LSUB_PIPE_MAX)
    else $error("unified cycle started at deep pipe");

  chk_one_txn: assert property (
    !(lm_req && um_req))
    else $error("two transactions in flight");

  chk_sram_block: assert property (
    state == LSUB_ST_IDLE && us_req && us_local && sram_prot |=> us_err && !lm_req)
    else $error("unified access reached protected sram");

  chk_spec_retry: assert property (
    state == LSUB_ST_IDLE && !us_req && ls_req && !ls_local && ls_spec && !data_relocate_bit
      |=> ls_retry && !ls_dsi && !prot_irq)
    else $error("speculative access not retried");

  chk_dsi_cause: assert property (
    $rose(ls_dsi) |-> $past(data_relocate_bit) && prot_irq)
    else $error("storage exception without cause");

  chk_show_mode: assert property (
    $rose(um_show) |-> show_mode != LSUB_SHOW_NONE && $past(state) == LSUB_ST_SHOW)
    else $error("show cycle with show cycles off");

  chk_in_answer: assert property (
    lm_req && lm_ack |=> us_ack && !lm_req ##1 !lm_req)
    else $error("inbound access not closed before next");

endmodule

// File: pkg/lsub_pkg.sv
// constants, field layout and state codes for the load/store to unified bus bridge
package lsub_pkg;

  // --------------------------------------------------------------------------
  // register offsets (byte addresses)
  // --------------------------------------------------------------------------
  localparam logic [7:0] LSUB_OFF_RBA0 = 8'h00;
  localparam logic [7:0] LSUB_OFF_RA0  = 8'h10;
  localparam logic [7:0] LSUB_OFF_GRA  = 8'h20;
  localparam logic [7:0] LSUB_OFF_CTRL = 8'h24;
  localparam logic [7:0] LSUB_OFF_LBLK = 8'h28;
  localparam logic [7:0] LSUB_OFF_STAT = 8'h2c;

  // --------------------------------------------------------------------------
  // field positions
  // --------------------------------------------------------------------------
  localparam int LSUB_RA_SIZE_LSB = 0;
  localparam int LSUB_RA_SIZE_W   = 4;
  localparam int LSUB_RA_SUPER    = 4;
  localparam int LSUB_RA_GUARD    = 5;
  localparam int LSUB_RA_RDONLY   = 6;
  localparam int LSUB_GRA_EN_LSB  = 8;
  localparam int LSUB_CTRL_SPROT  = 0;
  localparam int LSUB_CTRL_SHOW   = 1;
  localparam int LSUB_BASE_LSB    = 12;

  // --------------------------------------------------------------------------
  // region sizes: 4 Kbytes (2^12) up to 16 Mbytes (2^24)
  // --------------------------------------------------------------------------
  localparam int                         LSUB_MIN_SIZE_LOG2 = 12;
  localparam logic [LSUB_RA_SIZE_W-1:0]  LSUB_MAX_SIZE_CODE = 4'hc;
  localparam logic [1:0]                 LSUB_PIPE_MAX      = 2'h1;

  // --------------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------------
  localparam logic [31:0] LSUB_RST_RBA  = 32'h0000_0000;
  localparam logic [31:0] LSUB_RST_RA   = 32'h0000_0000;
  localparam logic [31:0] LSUB_RST_GRA  = 32'h0000_0000;
  localparam logic [31:0] LSUB_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] LSUB_RST_LBLK = 32'h0000_0000;

  typedef enum logic [1:0] {
    LSUB_SHOW_NONE   = 2'b00,
    LSUB_SHOW_ALL    = 2'b01,
    LSUB_SHOW_WRITES = 2'b10
  } lsub_show_t;

  typedef enum logic [2:0] {
    LSUB_ST_IDLE = 3'b000,
    LSUB_ST_IN   = 3'b001,
    LSUB_ST_WAIT = 3'b010,
    LSUB_ST_OUT  = 3'b011,
    LSUB_ST_SHOW = 3'b100,
    LSUB_ST_GAP  = 3'b101
  } lsub_state_t;

endpackage

// File: core/lsub_region.sv
// one protection region address comparator
`timescale 1ns/1ps
module lsub_region
  import lsub_pkg::*;
(
  // region programming
  input  wire logic [31:0] base,
  input  wire logic [31:0] attr,
  input  wire logic        en,
  // access
  input  wire logic [31:0] addr,
  output logic             hit
);
  import lsub_pkg::*;

  logic [LSUB_RA_SIZE_W-1:0] code;
  logic [31:0]               mask;

  always_comb begin
    code = attr[LSUB_RA_SIZE_LSB +: LSUB_RA_SIZE_W];
    // codes above 16 Mbytes clamp so a bad value never widens past the top size
    if (code > LSUB_MAX_SIZE_CODE) begin
      code = LSUB_MAX_SIZE_CODE;
    end
    mask = 32'hffff_ffff << (LSUB_MIN_SIZE_LOG2 + int'(code));
    hit  = en && (((addr ^ base) & mask) == 32'h0000_0000);
  end

endmodule

// File: core/lsub_dpu.sv
// data protection unit: four regions plus a global default entry
`timescale 1ns/1ps
module lsub_dpu
  import lsub_pkg::*;
#(
  parameter int NREG = 4
) (
  // programming
  input  wire logic [NREG-1:0][31:0] rba,
  input  wire logic [NREG-1:0][31:0] ra,
  input  wire logic [31:0]           gra,
  // access and effective attributes
  input  wire logic [31:0]           addr,
  output logic                       super_only,
  output logic                       guarded,
  output logic                       rdonly
);
  import lsub_pkg::*;

  logic [NREG-1:0] hit;

  for (genvar i = 0; i < NREG; i++) begin : g_reg
    lsub_region u_region (
      .base (rba[i]),
      .attr (ra[i]),
      .en   (gra[LSUB_GRA_EN_LSB + i]),
      .addr (addr),
      .hit  (hit[i])
    );
  end

  always_comb begin
    // global entry applies when nothing matches
    super_only = gra[LSUB_RA_SUPER];
    guarded    = gra[LSUB_RA_GUARD];
    rdonly     = 1'b0;
    // walk down so the lowest region number wins
    for (int i = NREG - 1; i >= 0; i--) begin
      if (hit[i]) begin
        super_only = ra[i][LSUB_RA_SUPER];
        guarded    = ra[i][LSUB_RA_GUARD];
        rdonly     = ra[i][LSUB_RA_RDONLY];
      end
    end
  end

endmodule

// File: tb/lsub_far_model.sv
// far side model: answers the bridge on the load/store bus and the unified bus
`timescale 1ns/1ps
module lsub_far_model (
  // bench control
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        pipe_busy,
  // load/store bus slave
  input  wire logic        lm_req,
  input  wire logic [31:0] lm_addr,
  output logic             lm_ack,
  output logic [31:0]      lm_rdata,
  // unified bus slave
  input  wire logic        um_req,
  input  wire logic [31:0] um_addr,
  output logic             um_ack,
  output logic [31:0]      um_rdata,
  output logic [1:0]       um_pipe_depth
);
  logic [3:0]  lm_wait = 4'h0;
  logic [3:0]  um_wait = 4'h0;
  logic [31:0] noise   = 32'h5a5a_0f0f;

  initial begin
    lm_ack = 1'b0;
    um_ack = 1'b0;
  end

  // another master holding two stages keeps the bridge from starting
  assign um_pipe_depth = pipe_busy ? 2'h2 : 2'h0;

  // --------------------------------------------------------------------------
  // replies: read data is the inverted address; between replies the data
  // lines change every cycle so a stale sample cannot pass for a good one
  // --------------------------------------------------------------------------
  always @(posedge clk) begin
    noise    <= {noise[30:0], noise[31] ^ noise[21]};
    lm_ack   <= 1'b0;
    lm_rdata <= noise;
    if (lm_req === 1'b1 && lm_ack !== 1'b1) begin
      lm_wait <= lm_wait + 4'h1;
      if (lm_wait >= (slow ? 4'h6 : 4'h0)) begin
        lm_ack   <= 1'b1;
        lm_rdata <= ~lm_addr;
        lm_wait  <= 4'h0;
      end
    end
  end

  always @(posedge clk) begin
    um_ack   <= 1'b0;
    um_rdata <= ~noise;
    if (um_req === 1'b1 && um_ack !== 1'b1) begin
      um_wait <= um_wait + 4'h1;
      if (um_wait >= (slow ? 4'h5 : 4'h0)) begin
        um_ack   <= 1'b1;
        um_rdata <= ~um_addr;
        um_wait  <= 4'h0;
      end
    end
  end
endmodule

// File: tb/lsub_bridge_tb.sv
// self-checking bench for the load/store to unified bus bridge
`timescale 1ns/1ps
module lsub_bridge_tb;
  import lsub_pkg::*;
  logic        clk, rst, soft_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, ls_addr, ls_wdata, ls_rdata, lm_addr, lm_wdata, lm_rdata;
  logic        ls_req, ls_we, ls_user, ls_spec, ls_cancel, data_relocate_bit;
  logic        ls_ack, ls_retry, ls_dsi, ls_mod_sel, prot_irq;
  logic        lm_req, lm_we, lm_ack, us_req, us_we, us_ack, us_err;
  logic [31:0] us_addr, us_wdata, us_rdata, um_addr, um_wdata, um_rdata;
  logic        um_req, um_we, um_show, um_ack, slow, pipe_busy;
  logic [1:0]  um_pipe_depth;
  logic [31:0] rd, res, err, n_irq, n_show, n_sel;
  int          mismatches, checks_done;
  time         t_us, t_ls;

  lsub_bridge i_dut (
    .clk, .rst, .soft_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
    .ls_req, .ls_addr, .ls_we, .ls_wdata, .ls_user, .ls_spec, .ls_cancel, .data_relocate_bit,
    .ls_ack, .ls_retry, .ls_dsi, .ls_rdata, .ls_mod_sel, .prot_irq,
    .lm_req, .lm_addr, .lm_we, .lm_wdata, .lm_ack, .lm_rdata,
    .us_req, .us_addr, .us_we, .us_wdata, .us_ack, .us_err, .us_rdata,
    .um_req, .um_addr, .um_we, .um_wdata, .um_show, .um_ack, .um_rdata, .um_pipe_depth
  );

  lsub_far_model i_far (
    .clk, .slow, .pipe_busy, .lm_req, .lm_addr, .lm_ack, .lm_rdata,
    .um_req, .um_addr, .um_ack, .um_rdata, .um_pipe_depth
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // event counters, cleared by each processor request
  always @(posedge clk) begin
    if (prot_irq === 1'b1) n_irq <= n_irq + 32'h1;
    if (um_show === 1'b1 && um_ack === 1'b1) n_show <= n_show + 32'h1;
    if (ls_mod_sel === 1'b1) n_sel <= n_sel + 32'h1;
  end

  // --------------------------------------------------------------------------
  // tasks; each starts and ends just after a rising edge
  // --------------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
    if (n >= 50) mismatches++;
  endtask

  task automatic ls(input logic [31:0] a, input logic we, input logic user, input logic spec);
    int n;
    n_irq  = 32'h0;
    n_show = 32'h0;
    n_sel  = 32'h0;
    ls_req   <= 1'b1;
    ls_addr  <= a;
    ls_we    <= we;
    ls_wdata <= ~a;
    ls_user  <= user;
    ls_spec  <= spec;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ls_ack !== 1'b1 && ls_retry !== 1'b1 && ls_dsi !== 1'b1 && n < 200);
    res  = ls_dsi === 1'b1 ? 32'h3 : ls_retry === 1'b1 ? 32'h2 : 32'h1;
    rd   = ls_rdata;
    t_ls = $time;
    ls_req <= 1'b0;
    @(posedge clk);
    if (n >= 200) mismatches++;
  endtask

  task automatic us(input logic [31:0] a, input logic we);
    int n;
    us_req   <= 1'b1;
    us_addr  <= a;
    us_we    <= we;
    us_wdata <= ~a;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (us_ack !== 1'b1 && us_err !== 1'b1 && n < 200);
    res  = us_err === 1'b1 ? 32'h3 : 32'h1;
    rd   = us_rdata;
    t_us = $time;
    us_req <= 1'b0;
    @(posedge clk);
    if (n >= 200) mismatches++;
  endtask

  task automatic prot(input logic [31:0] ra0, input logic [31:0] gra, input logic dr, input logic [31:0] a,
                      input logic we, input logic user, input logic spec, input logic [31:0] r, input logic [31:0] irq);
    apb(1'b1, LSUB_OFF_RA0, ra0);
    apb(1'b1, LSUB_OFF_GRA, gra);
    data_relocate_bit <= dr;
    ls(a, we, user, spec);
    check("access outcome", res, r);
    check("protection irq", n_irq, irq);
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // a full run takes a few hundred cycles
  initial begin
    #500000;
    mismatches++;
    wrap_up;
  end

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    {rst, soft_rst, psel, penable, pwrite, ls_req, ls_we, ls_user, ls_spec} = 9'h100;
    {ls_cancel, data_relocate_bit, us_req, us_we, slow, pipe_busy} = 6'h00;
    {paddr, pwdata, ls_addr, ls_wdata, us_addr, us_wdata} = '0;
    {n_irq, n_show, n_sel} = '0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 12; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("register reset", rd, 32'h0);
    end
    apb(1'b0, 8'h30, 32'h0);
    check("unmapped error", err, 32'h1);
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      ls(32'h0010_0000, 1'b0, 1'b0, 1'b0);
      check("forward load", rd, 32'hffef_ffff);
      ls(32'h0020_0000, 1'b1, 1'b0, 1'b0);
      check("forward store", res, 32'h1);
      check("store data out", um_wdata, 32'hffdf_ffff);
      check("store dir out", {31'h0, um_we}, 32'h1);
      us(32'h0000_0100, 1'b0);
      check("inbound read", rd, 32'hffff_feff);
    end
    slow <= 1'b0;
    fork
      ls(32'h0030_0000, 1'b0, 1'b0, 1'b0);
      us(32'h0000_0200, 1'b1);
    join
    check("inbound first", {31'h0, t_us < t_ls}, 32'h1);
    check("inbound data", lm_wdata, 32'hffff_fdff);
    check("inbound dir", {31'h0, lm_we}, 32'h1);
    pipe_busy <= 1'b1;
    fork
      ls(32'h0040_0000, 1'b0, 1'b0, 1'b0);
      begin
        repeat (12) @(posedge clk);
        check("start held", {31'h0, um_req}, 32'h0);
        pipe_busy <= 1'b0;
      end
    join
    check("start after depth", res, 32'h1);
    pipe_busy <= 1'b1;
    ls_req    <= 1'b1;
    ls_addr   <= 32'h0060_0000;
    repeat (3) @(posedge clk);
    {ls_req, ls_cancel} <= 2'b01;
    @(posedge clk);
    {ls_cancel, pipe_busy} <= 2'b00;
    repeat (2) @(posedge clk);
    check("cancelled start", {31'h0, um_req}, 32'h0);
    apb(1'b1, LSUB_OFF_CTRL, 32'h1);
    us(32'h0000_0100, 1'b0);
    check("sram read blocked", res, 32'h3);
    us(32'h0000_0104, 1'b1);
    check("sram write blocked", res, 32'h3);
    for (int m = 0; m < 3; m++) begin
      apb(1'b1, LSUB_OFF_CTRL, 32'(m << 1));
      ls(32'h0000_0040, 1'b0, 1'b0, 1'b0);
      check("show on read", n_show, 32'(m == 1));
      check("module select", n_sel, 32'h1);
      ls(32'h0000_0044, 1'b1, 1'b0, 1'b0);
      check("show on write", n_show, 32'(m != 0));
    end
    apb(1'b1, LSUB_OFF_RBA0, 32'h0010_0000);
    apb(1'b1, LSUB_OFF_RBA0 + 8'h04, 32'h0010_0000);
    apb(1'b1, LSUB_OFF_RA0 + 8'h04, 32'h10);
    prot(32'h10, 32'h100, 1'b1, 32'h0010_0010, 1'b0, 1'b1, 1'b0, 32'h3, 32'h1);
    prot(32'h10, 32'h100, 1'b1, 32'h0010_0010, 1'b0, 1'b0, 1'b0, 32'h1, 32'h0);
    prot(32'h10, 32'h100, 1'b1, 32'h0010_1000, 1'b0, 1'b1, 1'b0, 32'h1, 32'h0);
    prot(32'h20, 32'h100, 1'b1, 32'h0010_0010, 1'b0, 1'b0, 1'b1, 32'h2, 32'h1);
    prot(32'h40, 32'h100, 1'b1, 32'h0010_0010, 1'b1, 1'b0, 1'b0, 32'h3, 32'h1);
    apb(1'b0, LSUB_OFF_STAT, 32'h0);
    check("last event", rd, 32'h0000_0030);
    prot(32'h00, 32'h300, 1'b1, 32'h0010_0010, 1'b0, 1'b1, 1'b0, 32'h1, 32'h0);
    prot(32'h10, 32'h000, 1'b1, 32'h0010_0010, 1'b0, 1'b1, 1'b0, 32'h1, 32'h0);
    prot(32'h10, 32'h110, 1'b1, 32'h0010_2000, 1'b0, 1'b1, 1'b0, 32'h3, 32'h1);
    prot(32'h10, 32'h110, 1'b1, 32'h0000_0100, 1'b0, 1'b1, 1'b0, 32'h1, 32'h0);
    prot(32'h10, 32'h100, 1'b0, 32'h0010_0010, 1'b0, 1'b1, 1'b0, 32'h1, 32'h0);
    prot(32'h10, 32'h100, 1'b0, 32'h0050_0000, 1'b0, 1'b0, 1'b1, 32'h2, 32'h0);
    apb(1'b1, LSUB_OFF_RBA0, 32'h0100_0000);
    prot(32'h1c, 32'h100, 1'b1, 32'h01ff_fff0, 1'b0, 1'b1, 1'b0, 32'h3, 32'h1);
    prot(32'h1c, 32'h100, 1'b1, 32'h0200_0000, 1'b0, 1'b1, 1'b0, 32'h1, 32'h0);
    apb(1'b1, LSUB_OFF_GRA, 32'hffff_ffff);
    apb(1'b0, LSUB_OFF_GRA, 32'h0);
    check("global fields", rd, 32'h0000_0f30);
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, LSUB_OFF_GRA, 32'h0);
    check("kept on soft reset", rd, 32'h0000_0f30);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, LSUB_OFF_GRA, 32'h0);
    check("cleared on hard reset", rd, 32'h0);
    wrap_up;
  end
endmodule
